// >>> verilog/cbp_pkg.sv
//------------------------------------------------------------
// Behaviour
// - Read-only bit shows parity logic built in
// - Parity check enable, changed only while disabled
// - Store computed parity bit with written word
// - Receive data read with mismatch sets flag
// - Each partial read of bad word sets flag
// - Clear commands clear receive and transmit flags only while checking enabled
// - Receive mismatches ignored while checking disabled
// - Test path writes keep stored parity bit
// - Header word fault stops frame before start
// - Payload word fault starts error frame
// - Transmit fault: buffer to parity state, flag
// - Transmit mismatches ignored while checking disabled
// - Backup mode pairs adjacent buffers, higher backs
// - Original fault sends backup; success aborts backup
// - Fault in rescuing backup sets double flag
// - Pair uses priority of original buffer
// - Commands to original also reach backup
// - Backup mode without checking never sends backup
// - Higher priority ready buffer beats backup
//------------------------------------------------------------
package cbp_pkg;
    localparam logic PARITY_BUILT = 1'b1;
    localparam logic PAR_ODD = 1'b0;
    localparam int REG_AW = 9;
    localparam int TXB_N = 4;
    localparam int RX_AW = 5;
    localparam int TX_AW = 6;
    localparam int HDR_WORDS = 4;
    localparam int PRIO_W = 3;
    localparam int TXST_W = 4;
    localparam int TXWIN_BIT = 8;
    localparam logic [8:0] A_STATUS = 9'h008;
    localparam logic [8:0] A_COMMAND = 9'h00c;
    localparam logic [8:0] A_SETTINGS = 9'h010;
    localparam logic [8:0] A_TXCMD = 9'h014;
    localparam logic [8:0] A_TXPRIO = 9'h018;
    localparam logic [8:0] A_TXSTATE = 9'h01c;
    localparam logic [8:0] A_RXSTAT = 9'h068;
    localparam logic [8:0] A_RXDATA = 9'h06c;
    localparam int ST_RXPF = 10;
    localparam int ST_TXPF = 11;
    localparam int ST_DPF = 12;
    localparam int ST_BUILT = 13;
    localparam int CM_FLUSH = 1;
    localparam int CM_MOVE = 2;
    localparam int CM_CLR_RX = 9;
    localparam int CM_CLR_TX = 10;
    localparam int TC_READY = 8;
    localparam int TC_ABORT = 9;
    localparam int TC_EMPTY = 10;
    localparam int RS_NOTEMPTY = 0;
    localparam int RS_MIDFRAME = 2;
    localparam logic [3:0] SET_RST = 4'h0;
    localparam logic [11:0] PRIO_RST = 12'h000;

    typedef enum logic [2:0] {
        TXS_EMPTY = 3'b000,
        TXS_READY = 3'b001,
        TXS_TXING = 3'b010,
        TXS_OK = 3'b011,
        TXS_FAILED = 3'b100,
        TXS_ABORTED = 3'b101,
        TXS_PERR = 3'b110
    } cbp_txst_t;

    typedef struct packed {
        logic first;
        logic [31:0] data;
    } cbp_rxw_t;

    typedef struct packed {
        logic valid;
        logic toTx;
        logic [5:0] addr;
        logic [31:0] data;
    } cbp_tstw_t;
endpackage

// >>> verilog/cbp_parity_ram.sv
`timescale 1ns/10ps
module cbp_parity_ram #(
    parameter int W = 32,
    parameter int AW = 5
) (
    input wire logic clk, // Core clock
    input wire logic wrEn, // Functional write
    input wire logic [AW-1:0] wrAddr, // Functional write address
    input wire logic [W-1:0] wrData, // Functional write data
    input wire logic tstEn, // Test path write
    input wire logic [AW-1:0] tstAddr, // Test path address
    input wire logic [W-1:0] tstData, // Test path data
    input wire logic [AW-1:0] rdAddr, // Read address
    output logic [W-1:0] rdData, // Registered read data
    output logic rdPar // Registered stored parity
);
    import cbp_pkg::*;

    logic [W-1:0] mem [2**AW];
    logic par [2**AW];

    //------------------------------------------------------------
    // Storage
    //------------------------------------------------------------
    // Test writes leave parity alone so faults can be injected
    always_ff @(posedge clk)
    begin
        if (wrEn)
        begin
            mem[wrAddr] <= wrData;
            par[wrAddr] <= ^wrData ^ PAR_ODD;
        end
        else if (tstEn)
        begin
            mem[tstAddr] <= tstData;
        end
        rdData <= mem[rdAddr];
        rdPar <= par[rdAddr];
    end
endmodule

// >>> verilog/cbp_txb_fsm.sv
`timescale 1ns/10ps
module cbp_txb_fsm (
    input wire logic clk, // Core clock
    input wire logic reset, // Synchronous reset
    input wire logic cmdReady, // Set ready command
    input wire logic cmdAbort, // Abort command
    input wire logic cmdEmpty, // Set empty command
    input wire logic start, // Core takes this buffer
    input wire logic parErr, // Parity fault on this buffer
    input wire logic okDone, // Sent successfully
    input wire logic failDone, // Send failed
    input wire logic bkAbort, // Original succeeded, drop backup
    output cbp_pkg::cbp_txst_t state // Buffer state
);
    import cbp_pkg::*;

    cbp_txst_t next_state;

    //------------------------------------------------------------
    // Buffer state machine
    //------------------------------------------------------------
    // Aborting a buffer on the bus is not supported; it must finish
    always_comb
    begin
        next_state = state;
        case (state)
            TXS_READY:
            begin
                if (start)
                    next_state = TXS_TXING;
                else if (cmdAbort || bkAbort)
                    next_state = TXS_ABORTED;
            end
            TXS_TXING:
            begin
                if (parErr)
                    next_state = TXS_PERR;
                else if (okDone)
                    next_state = TXS_OK;
                else if (failDone)
                    next_state = TXS_FAILED;
            end
            TXS_EMPTY, TXS_OK, TXS_FAILED, TXS_ABORTED, TXS_PERR:
            begin
                if (cmdReady)
                    next_state = TXS_READY;
                else if (cmdEmpty)
                    next_state = TXS_EMPTY;
            end
            default:
                next_state = TXS_EMPTY;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            state <= TXS_EMPTY;
        else
            state <= next_state;
    end
endmodule

// >>> verilog/cbp_parity_core.sv
`timescale 1ns/10ps
module cbp_parity_core (
    input wire logic clk, // Core clock, 125 MHz
    input wire logic reset, // Synchronous reset
    input wire logic [cbp_pkg::REG_AW-1:0] regAddr, // Byte address
    input wire logic [31:0] regWdata, // Write data
    input wire logic regWr, // Write strobe
    input wire logic regRd, // Read strobe
    output logic [31:0] regRdata, // Read data, cycle after strobe
    input wire cbp_pkg::cbp_tstw_t tstWr, // Test path write
    input wire logic rxStoreValid, // Received word offered
    input wire cbp_pkg::cbp_rxw_t rxStore, // Received word
    output logic rxStoreReady, // Receive buffer has room
    output logic controllerEnable, // Controller enabled
    output logic txSelValid, // A buffer is offered
    output logic [1:0] txSelBuf, // Offered buffer
    input wire logic txStart, // Core takes offered buffer
    input wire logic txRdEn, // Core reads a word
    input wire logic [3:0] txRdWord, // Word index in buffer
    output logic txRdValid, // Word read answer
    output logic [31:0] txRdData, // Word read data
    output logic txStop, // Header fault, do not send
    output logic txErrorFrame, // Payload fault, send error frame
    input wire logic txDone, // Transmission ended
    input wire logic txOk // Transmission succeeded
);
    import cbp_pkg::*;

    logic pchk;
    logic bbm;
    logic autoRd;
    logic [TXB_N*PRIO_W-1:0] prio;
    logic rxFault;
    logic txFault;
    logic dpf;
    logic [RX_AW:0] rxWp;
    logic [RX_AW:0] rxRp;
    logic [RX_AW:0] rxWpSeen;
    logic [RX_AW:0] next_rxRp;
    logic [32:0] rxQraw;
    logic rxQpar;
    cbp_rxw_t rxQ;
    logic [31:0] txQ;
    logic txQpar;
    logic txRdHdr;
    logic [1:0] curBuf;
    logic rescueRun;
    cbp_txst_t txSt [TXB_N];
    logic [PRIO_W-1:0] effPrio [TXB_N];
    logic [TXB_N-1:0] elig;
    logic [TXB_N-1:0] rescue;
    logic [TXB_N-1:0] txing;
    logic [TXB_N*TXST_W-1:0] stWord;
    logic selValid;
    logic [1:0] selBuf;
    logic [PRIO_W-1:0] bestPrio;
    logic [31:0] next_regRdata;

    //------------------------------------------------------------
    // Register decode
    //------------------------------------------------------------
    // Strobes qualified by address
    wire wrCmd = regWr && (regAddr == A_COMMAND);
    wire wrSet = regWr && (regAddr == A_SETTINGS);
    wire wrTxCmd = regWr && (regAddr == A_TXCMD);
    wire wrPrio = regWr && (regAddr == A_TXPRIO);
    wire wrTxBuf = regWr && regAddr[TXWIN_BIT];
    wire rdRxData = regRd && (regAddr == A_RXDATA);
    wire parityOn = PARITY_BUILT && pchk;
    wire clrRx = wrCmd && regWdata[CM_CLR_RX] && parityOn;
    wire clrTx = wrCmd && regWdata[CM_CLR_TX] && parityOn;
    wire flush = wrCmd && regWdata[CM_FLUSH];
    wire moveCmd = wrCmd && regWdata[CM_MOVE];

    //------------------------------------------------------------
    // Settings and priorities
    //------------------------------------------------------------
    // Parity mode bits freeze while enabled, so a frame never sees them change
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            {autoRd, bbm, pchk, controllerEnable} <= SET_RST;
            prio <= PRIO_RST;
        end
        else
        begin
            if (wrSet)
            begin
                controllerEnable <= regWdata[0];
                autoRd <= regWdata[3];
                if (!controllerEnable)
                begin
                    pchk <= regWdata[1];
                    bbm <= regWdata[2];
                end
            end
            if (wrPrio)
                prio <= regWdata[TXB_N*PRIO_W-1:0];
        end
    end

    //------------------------------------------------------------
    // Receive buffer pointers
    //------------------------------------------------------------
    // Empty uses a write pointer one cycle late so read data are settled
    wire rxFull = (rxWp[RX_AW] != rxRp[RX_AW]) &&
        (rxWp[RX_AW-1:0] == rxRp[RX_AW-1:0]);
    wire rxEmpty = (rxWpSeen == rxRp);
    wire rxPush = rxStoreValid && !rxFull;
    wire rxAdvance = !rxEmpty && (autoRd ? rdRxData : moveCmd);
    assign rxStoreReady = !rxFull;
    assign next_rxRp = flush ? rxWp : (rxAdvance ? rxRp + 1'b1 : rxRp);

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rxWp <= '0;
            rxRp <= '0;
            rxWpSeen <= '0;
        end
        else
        begin
            if (rxPush)
                rxWp <= rxWp + 1'b1;
            rxRp <= next_rxRp;
            rxWpSeen <= rxWp;
        end
    end

    // Read address runs one step ahead so the port always shows the head word
    cbp_parity_ram #(
        .W(33),
        .AW(RX_AW)
    ) u_rxRam (
        .clk(clk),
        .wrEn(rxPush),
        .wrAddr(rxWp[RX_AW-1:0]),
        .wrData(rxStore),
        .tstEn(tstWr.valid && !tstWr.toTx),
        .tstAddr(tstWr.addr[RX_AW-1:0]),
        .tstData({1'b0, tstWr.data}),
        .rdAddr(next_rxRp[RX_AW-1:0]),
        .rdData(rxQraw),
        .rdPar(rxQpar)
    );
    assign rxQ = rxQraw;

    //------------------------------------------------------------
    // Receive parity check
    //------------------------------------------------------------
    // Every read checks, so a word read piecewise flags on each access
    wire rxMisRaw = ((^rxQraw) ^ PAR_ODD) != rxQpar;
    wire rxHit = rdRxData && !rxEmpty && parityOn && rxMisRaw;
    wire rxMid = !rxEmpty && !rxQ.first;

    //------------------------------------------------------------
    // Transmit buffer memory
    //------------------------------------------------------------
    // Four buffers of sixteen words each share one memory
    cbp_parity_ram #(
        .W(32),
        .AW(TX_AW)
    ) u_txRam (
        .clk(clk),
        .wrEn(wrTxBuf),
        .wrAddr(regAddr[TX_AW+1:2]),
        .wrData(regWdata),
        .tstEn(tstWr.valid && tstWr.toTx),
        .tstAddr(tstWr.addr),
        .tstData(tstWr.data),
        .rdAddr({curBuf, txRdWord}),
        .rdData(txQ),
        .rdPar(txQpar)
    );

    //------------------------------------------------------------
    // Transmit read answer
    //------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            txRdValid <= 1'b0;
            txRdHdr <= 1'b0;
        end
        else
        begin
            txRdValid <= txRdEn;
            txRdHdr <= txRdWord < 4'(HDR_WORDS);
        end
    end

    // Fault pulses are combinational so the core reacts in the answer cycle
    wire txMisRaw = ((^txQ) ^ PAR_ODD) != txQpar;
    wire txMis = txRdValid && parityOn && txMisRaw;
    assign txRdData = txQ;
    assign txStop = txMis && txRdHdr;
    assign txErrorFrame = txMis && !txRdHdr;

    //------------------------------------------------------------
    // Sticky fault flags
    //------------------------------------------------------------
    // A new fault in the clearing cycle survives the clear
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rxFault <= 1'b0;
            txFault <= 1'b0;
            dpf <= 1'b0;
        end
        else
        begin
            rxFault <= rxHit || (rxFault && !clrRx);
            txFault <= txMis || (txFault && !clrTx);
            dpf <= (txMis && rescueRun) || (dpf && !clrTx);
        end
    end

    //------------------------------------------------------------
    // Transmit buffers
    //------------------------------------------------------------
    wire txStartOk = txStart && txSelValid;
    wire okEnd = txDone && txOk;
    wire failEnd = txDone && !txOk;

    for (genvar i = 0; i < TXB_N; i++)
    begin : g_buf
        localparam int ORIG = i - (i % 2);
        localparam bit IS_BK = (i % 2) == 1;
        wire hit = regWdata[i] || (IS_BK && bbm && regWdata[ORIG]);
        wire mine = curBuf == 2'(i);
        // Backup shares the original's priority
        assign effPrio[i] = bbm ? prio[ORIG*PRIO_W +: PRIO_W]
            : prio[i*PRIO_W +: PRIO_W];
        // Backup may go only after its original failed on parity
        assign rescue[i] = IS_BK && parityOn && (txSt[ORIG] == TXS_PERR);
        assign elig[i] = (txSt[i] == TXS_READY) && !(IS_BK && bbm && !rescue[i]);
        assign txing[i] = txSt[i] == TXS_TXING;
        assign stWord[i*TXST_W +: TXST_W] = {1'b0, txSt[i]};

        cbp_txb_fsm u_fsm (
            .clk(clk),
            .reset(reset),
            .cmdReady(wrTxCmd && hit && regWdata[TC_READY]),
            .cmdAbort(wrTxCmd && hit && regWdata[TC_ABORT]),
            .cmdEmpty(wrTxCmd && hit && regWdata[TC_EMPTY]),
            .start(txStartOk && (selBuf == 2'(i))),
            .parErr(txMis && mine),
            .okDone(okEnd && mine),
            .failDone(failEnd && mine),
            .bkAbort(IS_BK && bbm && okEnd && (curBuf == 2'(ORIG))),
            .state(txSt[i])
        );
    end

    //------------------------------------------------------------
    // Buffer selection
    //------------------------------------------------------------
    // Highest priority wins, lower index on a tie, so a newly ready
    // buffer above the failed pair goes ahead of the backup
    always_comb
    begin
        selValid = 1'b0;
        selBuf = 2'b00;
        bestPrio = '0;
        for (int i = 0; i < TXB_N; i++)
        begin
            if (elig[i] && (!selValid || effPrio[i] > bestPrio))
            begin
                selValid = 1'b1;
                selBuf = 2'(i);
                bestPrio = effPrio[i];
            end
        end
    end

    // Nothing is offered while a buffer is on the bus
    assign txSelValid = selValid && !(|txing);
    assign txSelBuf = selBuf;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            curBuf <= 2'b00;
            rescueRun <= 1'b0;
        end
        else if (txStartOk)
        begin
            curBuf <= selBuf;
            rescueRun <= bbm && rescue[selBuf];
        end
    end

    //------------------------------------------------------------
    // Read data
    //------------------------------------------------------------
    // Unmapped and write-only addresses read zero
    wire [31:0] statusWord = 32'({PARITY_BUILT, dpf, txFault, rxFault}) << ST_RXPF;
    wire [31:0] rxStatWord = 32'({rxMid, 1'b0, !rxEmpty});

    assign next_regRdata =
        (regAddr == A_STATUS) ? statusWord :
        (regAddr == A_SETTINGS) ? 32'({autoRd, bbm, pchk, controllerEnable}) :
        (regAddr == A_TXPRIO) ? 32'(prio) :
        (regAddr == A_TXSTATE) ? 32'(stWord) :
        (regAddr == A_RXSTAT) ? rxStatWord :
        (regAddr == A_RXDATA) ? rxQ.data :
        32'h0000_0000;

    always_ff @(posedge clk)
    begin
        if (reset)
            regRdata <= 32'h0000_0000;
        else
            regRdata <= regRd ? next_regRdata : 32'h0000_0000;
    end

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_hdrFault;
        txRdEn && (txRdWord < 4'(HDR_WORDS)) ##1 parityOn && txMisRaw;
    endsequence

    sequence s_payFault;
        txRdEn && (txRdWord >= 4'(HDR_WORDS)) ##1 parityOn && txMisRaw;
    endsequence

    property p_rxSet;
        rdRxData && !rxEmpty && parityOn && rxMisRaw |=> rxFault;
    endproperty
    a_rxSet: assert property (p_rxSet) else $error("rx fault not set");

    property p_rxOff;
        !parityOn && !rxFault |=> !rxFault;
    endproperty
    a_rxOff: assert property (p_rxOff) else $error("rx fault set while off");

    property p_clrRx;
        wrCmd && regWdata[CM_CLR_RX] && parityOn && !rdRxData |=> !rxFault;
    endproperty
    a_clrRx: assert property (p_clrRx) else $error("rx clear failed");

    property p_hdrStop;
        s_hdrFault |-> txStop && !txErrorFrame;
    endproperty
    a_hdrStop: assert property (p_hdrStop) else $error("header fault missed");

    property p_payErr;
        s_payFault |-> txErrorFrame && !txStop;
    endproperty
    a_payErr: assert property (p_payErr) else $error("payload fault missed");

    property p_txState;
        (s_hdrFault or s_payFault) ##0 txSt[curBuf] == TXS_TXING |=>
            txSt[curBuf] == TXS_PERR && txFault;
    endproperty
    a_txState: assert property (p_txState) else $error("no parity state");

    property p_txOff;
        !parityOn && !txFault |=> !txFault && !dpf;
    endproperty
    a_txOff: assert property (p_txOff) else $error("tx fault set while off");

    property p_mirror;
        wrTxCmd && bbm && regWdata[0] && regWdata[TC_READY] &&
            txSt[1] == TXS_EMPTY |=> txSt[1] == TXS_READY;
    endproperty
    a_mirror: assert property (p_mirror) else $error("command not mirrored");

    property p_bkAbort;
        bbm && okEnd && curBuf == 2'b00 && txSt[0] == TXS_TXING &&
            txSt[1] == TXS_READY |=> txSt[1] == TXS_ABORTED;
    endproperty
    a_bkAbort: assert property (p_bkAbort) else $error("backup not aborted");

    property p_noBackup;
        bbm && !parityOn |-> !(txSelValid && txSelBuf[0]);
    endproperty
    a_noBackup: assert property (p_noBackup) else $error("backup offered");

    property p_dpf;
        rescueRun && txRdValid && parityOn && txMisRaw |=> dpf;
    endproperty
    a_dpf: assert property (p_dpf) else $error("double fault missed");

    property p_frozen;
        controllerEnable && wrSet |=> $stable(pchk) && $stable(bbm);
    endproperty
    a_frozen: assert property (p_frozen) else $error("mode changed while on");
endmodule

// >>> testbench/tb_can_buffer_parity_backup.sv
`timescale 1ns/10ps
module tb_can_buffer_parity_backup;
import cbp_pkg::*;
logic clk, reset, regWr, regRd, rxStoreValid, txStart, txRdEn, txDone, txOk;
logic [REG_AW-1:0] regAddr;
logic [31:0] regWdata, regRdata, txRdData;
cbp_tstw_t tstWr;
cbp_rxw_t rxStore;
logic rxStoreReady, controllerEnable, txSelValid, txRdValid, txStop, txErrorFrame;
logic [1:0] txSelBuf;
logic [3:0] txRdWord;
logic [31:0] rdQ[$];
logic [33:0] txQ[$];
logic [31:0] w[16];
logic [31:0] tw[64];
logic [1:0] bsel;
int err_total, n_checks, cyc;
logic rdPend = 1'b0;

cbp_parity_core dut_u (.clk(clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .tstWr(tstWr), .rxStoreValid(rxStoreValid),
    .rxStore(rxStore), .rxStoreReady(rxStoreReady), .controllerEnable(controllerEnable),
    .txSelValid(txSelValid), .txSelBuf(txSelBuf), .txStart(txStart), .txRdEn(txRdEn),
    .txRdWord(txRdWord), .txRdValid(txRdValid), .txRdData(txRdData), .txStop(txStop),
    .txErrorFrame(txErrorFrame), .txDone(txDone), .txOk(txOk));

//----------------------------------------
// Clock, monitor and timeout
//----------------------------------------
initial
begin
    clk = 0;
    forever #4 clk = ~clk;
end

task automatic cmp(string nm, logic [33:0] e, logic [33:0] s);
    n_checks++;
    if (s !== e)
    begin
        err_total++;
        $display("BAD %s expected %h seen %h", nm, e, s);
    end
endtask

task summarize;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask

// Read data stand only in the cycle after the strobe, so oldest note is taken there
always @(posedge clk)
begin
    if (rdPend)
        cmp("regRdata", rdQ.size() ? rdQ.pop_front() : 32'hx, regRdata);
    if (txRdValid)
        cmp("txRead", txQ.size() ? txQ.pop_front() : 34'hx, {txStop, txErrorFrame, txRdData});
    rdPend <= regRd;
    cyc++;
    if (cyc == 6000)
    begin
        err_total++;
        summarize;
    end
end

//----------------------------------------
// Drivers: strobes are held until the next task changes them
//----------------------------------------
task automatic bus(bit wr, logic [8:0] a, logic [31:0] d);
    regWr <= wr;
    regRd <= !wr;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
endtask

task automatic rd(logic [8:0] a, logic [31:0] e);
    rdQ.push_back(e);
    bus(0, a, 32'h0);
endtask

// Test path write also drops the bus strobes; stored parity stays stale
task automatic bad(bit tx, logic [5:0] a, logic [31:0] d);
    if (tx)
        tw[a] = d;
    regWr <= 0;
    regRd <= 0;
    tstWr <= '{1'b1, tx, a, d};
    @(posedge clk);
    tstWr <= '0;
    @(posedge clk);
endtask

task automatic fill(int b);
    for (int k = 0; k < 16; k++)
    begin
        tw[b * 16 + k] = $urandom;
        bus(1, 9'(256 + b * 64 + k * 4), tw[b * 16 + k]);
    end
endtask

task automatic go(logic [1:0] b);
    bsel = b;
    bad(0, 6'h3f, 32'h0);
    cmp("txSelValid", 1, txSelValid);
    cmp("txSelBuf", b, txSelBuf);
    txStart <= 1;
    @(posedge clk);
    txStart <= 0;
    @(posedge clk);
endtask

task automatic txw(logic [3:0] k, logic [1:0] e);
    txQ.push_back({e, tw[{bsel, k}]});
    txRdEn <= 1;
    txRdWord <= k;
    @(posedge clk);
    txRdEn <= 0;
    repeat (2) @(posedge clk);
endtask

task automatic done;
    txDone <= 1;
    txOk <= 1;
    @(posedge clk);
    txDone <= 0;
    @(posedge clk);
endtask

//----------------------------------------
// Main sequence
//----------------------------------------
initial
begin
    reset = 1;
    {regWr, regRd, rxStoreValid, txStart, txRdEn, txDone, txOk} = '0;
    regAddr = '0;
    regWdata = '0;
    tstWr = '0;
    rxStore = '0;
    txRdWord = '0;
    void'($urandom(23798));
    repeat (3) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    rd(A_STATUS, 32'h2000);
    bus(1, A_SETTINGS, 32'h9);
    bus(1, A_SETTINGS, 32'hb);
    rd(A_SETTINGS, 32'h9);
    cmp("controllerEnable", 1, controllerEnable);
    bus(1, A_SETTINGS, 32'h8);
    bus(1, A_SETTINGS, 32'ha);
    bad(0, 6'h3f, 32'h0);
    // Three received words, the middle one flipped behind the parity's back
    for (int i = 0; i < 3; i++)
    begin
        w[i] = $urandom;
        rxStore <= '{i == 0, w[i]};
        rxStoreValid <= 1;
        @(posedge clk);
    end
    rxStoreValid <= 0;
    bad(0, 6'd1, w[1] ^ 32'h1);
    rd(A_RXDATA, w[0]);
    rd(A_STATUS, 32'h2000);
    rd(A_RXDATA, w[1] ^ 32'h1);
    rd(A_STATUS, 32'h2400);
    bus(1, A_COMMAND, 32'h200);
    rd(A_STATUS, 32'h2000);
    // Manual mode: every read of the bad head word with checking on raises the flag again
    bus(1, A_SETTINGS, 32'h2);
    bad(0, 6'd2, w[2] ^ 32'h10);
    rd(A_RXDATA, w[2] ^ 32'h10);
    bus(1, A_COMMAND, 32'h200);
    rd(A_RXDATA, w[2] ^ 32'h10);
    rd(A_STATUS, 32'h2400);
    bus(1, A_SETTINGS, 32'h0);
    bus(1, A_COMMAND, 32'h200);
    rd(A_RXDATA, w[2] ^ 32'h10);
    rd(A_STATUS, 32'h2400);
    // Software recovery: drain a mid-frame word, then flush a new frame
    rd(A_RXSTAT, 32'h5);
    bus(1, A_COMMAND, 32'h4);
    rd(A_RXSTAT, 32'h0);
    bad(0, 6'h3f, 32'h0);
    rxStore <= '{1'b1, $urandom};
    rxStoreValid <= 1;
    @(posedge clk);
    rxStoreValid <= 0;
    @(posedge clk);
    cmp("rxStoreReady", 1, rxStoreReady);
    rd(A_RXSTAT, 32'h1);
    bus(1, A_COMMAND, 32'h202);
    rd(A_RXSTAT, 32'h0);
    // Backup pairs: clean original sends, backup dropped
    bus(1, A_SETTINGS, 32'h7);
    bus(1, A_COMMAND, 32'h200);
    fill(0);
    fill(1);
    bus(1, A_TXCMD, 32'h101);
    go(0);
    txw(0, 0);
    txw(5, 0);
    done;
    rd(A_TXSTATE, 32'h0053);
    // Both buffers of the second pair faulty: original stops, backup also fails
    fill(2);
    fill(3);
    bad(1, 6'd32, tw[32] ^ 32'h4);
    bad(1, 6'd49, tw[49] ^ 32'h4);
    bus(1, A_TXCMD, 32'h104);
    go(2);
    txw(0, 2'b10);
    // Pair zero made ready above the failed pair goes first; backup priority ignored
    bus(1, A_TXPRIO, 32'he42);
    rd(A_TXPRIO, 32'he42);
    bus(1, A_TXCMD, 32'h101);
    go(0);
    done;
    go(3);
    txw(0, 0);
    txw(1, 2'b10);
    rd(A_STATUS, 32'h3800);
    rd(A_TXSTATE, 32'h6653);
    bus(1, A_COMMAND, 32'h400);
    rd(A_STATUS, 32'h2000);
    // Payload fault without backup mode
    bus(1, A_SETTINGS, 32'h6);
    bus(1, A_SETTINGS, 32'h3);
    fill(1);
    bad(1, 6'd22, tw[22] ^ 32'h100);
    bus(1, A_TXCMD, 32'h102);
    go(1);
    txw(0, 0);
    txw(6, 2'b01);
    rd(A_STATUS, 32'h2800);
    rd(A_TXSTATE, 32'h6663);
    // Checking off in backup mode: bad header sends, clear does nothing, no backup
    bus(1, A_SETTINGS, 32'h2);
    bus(1, A_SETTINGS, 32'h5);
    fill(0);
    bad(1, 6'd0, tw[0] ^ 32'h8);
    bus(1, A_TXCMD, 32'h109);
    go(0);
    txw(0, 0);
    done;
    cmp("txSelValid", 0, txSelValid);
    bus(1, A_COMMAND, 32'h400);
    rd(A_STATUS, 32'h2800);
    rd(A_TXSTATE, 32'h1653);
    bad(0, 6'h3f, 32'h0);
    repeat (2) @(posedge clk);
    summarize;
end
endmodule
